// ### pkg/acv_pkg.sv
// Package for the converter control block: timing, widths, carriers
package acv_pkg;
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned RES_BITS       = 8;
   localparam int unsigned CODE_COUNT     = 256;
   // Conversion time, microseconds
   localparam int unsigned CONV_TESTED_US = 40;
   localparam int unsigned CONV_DESIGN_US = 60;
   // Cycles: longest time rounds down
   localparam int unsigned CONV_TESTED_CYC = (CONV_TESTED_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned CONV_DESIGN_CYC = (CONV_DESIGN_US * 1000) / CLK_PERIOD_NS;
   // Host read holdoff after flag low, ns
   localparam int unsigned RD_HOLDOFF_NS  = 600;
   localparam int unsigned RD_HOLDOFF_CYC = (RD_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  RESULT_RST     = 8'h00;
   localparam logic [7:0]  CODE_ZERO      = 8'h00;
   localparam logic [7:0]  CODE_FULL      = 8'hff;

   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
   } acv_strobe_t;

   typedef struct packed {
      logic [RES_BITS-1:0] dout;
      logic [RES_BITS-1:0] oe;
   } acv_bus_t;
endpackage

// ### rtl/acv_sar.sv
// Successive-approximation register stepping one bit per clock
`timescale 1ns/100ps
module acv_sar
   import acv_pkg::*;
#(
   parameter int unsigned WIDTH = RES_BITS
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             start,
   input  wire logic             cmp_high,
   output logic [WIDTH-1:0]      trial,
   output logic                  busy,
   output logic                  done
);
   if (WIDTH < 2 || WIDTH > 16) begin
      $error("acv_sar: WIDTH out of range");
   end

   logic [WIDTH-1:0] code_r, code_nxt;
   logic [WIDTH-1:0] bit_r, bit_nxt;
   logic             busy_r, busy_nxt;
   logic             done_r, done_nxt;

   always_comb begin
      code_nxt = code_r;
      bit_nxt  = bit_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (start) begin
         code_nxt = {1'b1, {(WIDTH-1){1'b0}}};
         bit_nxt  = {1'b1, {(WIDTH-1){1'b0}}};
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         // Drop the trial bit when the input lies below it
         if (!cmp_high) code_nxt = code_r & ~bit_r;
         if (bit_r[0]) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end else begin
            bit_nxt  = bit_r >> 1;
            code_nxt = (cmp_high ? code_r : (code_r & ~bit_r)) | (bit_r >> 1);
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         code_r <= '0;
         bit_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         code_r <= code_nxt;
         bit_r  <= bit_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign trial = code_r;
   assign busy  = busy_r;
   assign done  = done_r;
endmodule

// ### rtl/acv_ctrl.sv
// Converter control: host strobes, conversion timing, result latch, bus drive
`timescale 1ns/100ps
module acv_ctrl
   import acv_pkg::*;
#(
   parameter int unsigned CONV_CYC = CONV_TESTED_CYC
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire acv_pkg::acv_strobe_t host_in,
   input  wire logic [RES_BITS-1:0] vin_pos,
   input  wire logic [RES_BITS-1:0] vin_neg,
   input  wire logic [RES_BITS-1:0] vref_span,
   output logic                     conversion_done_n,
   output acv_pkg::acv_bus_t        result_bus,
   output logic                     busy
);
   import acv_pkg::*;

   // SAR needs one clock per bit plus start and latch
   if (CONV_CYC < RES_BITS + 2 || CONV_CYC > CONV_DESIGN_CYC) begin
      $error("acv_ctrl: CONV_CYC outside conversion limits");
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   acv_strobe_t s1_r, s2_r, s3_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s1_r <= '1;
         s2_r <= '1;
         s3_r <= '1;
      end else begin
         s1_r <= host_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   logic wr_fall, wr_rise, rd_active, rd_rise;
   always_comb begin
      wr_fall   = !s2_r.cs_n && s3_r.wr_n && !s2_r.wr_n;
      wr_rise   = !s2_r.cs_n && !s3_r.wr_n && s2_r.wr_n;
      rd_active = !s2_r.cs_n && !s2_r.rd_n;
      rd_rise   = !s3_r.rd_n && s2_r.rd_n;
   end

   // ------------------------------------------------------------
   // Analog model as digital codes
   // ------------------------------------------------------------
   // Differential input scaled to the reference span
   function automatic logic [RES_BITS-1:0] acv_scale(input logic [RES_BITS-1:0] p,
                                                     input logic [RES_BITS-1:0] n,
                                                     input logic [RES_BITS-1:0] s);
      logic [2*RES_BITS-1:0] prod;
      logic [RES_BITS-1:0]   diff;
      logic [RES_BITS-1:0]   q;
      diff = 8'h00;
      prod = 16'h0000;
      q    = CODE_ZERO;
      if (n >= p) begin
         q = CODE_ZERO;
      end else begin
         diff = p - n;
         if (s == 8'h00 || diff >= s) begin
            q = CODE_FULL;
         end else begin
            prod = {diff, 8'h00};
            q = RES_BITS'(prod / {8'h00, s});
         end
      end
      return q;
   endfunction

   logic [RES_BITS-1:0] target_r, target_nxt;
   logic [RES_BITS-1:0] trial;
   logic                sar_done, sar_start;
   logic                cmp_high;

   always_comb begin
      cmp_high = target_r >= trial;
   end

   acv_sar #(
      .WIDTH    (RES_BITS)
   ) u_sar (
      .clock    (clock),
      .rst      (rst),
      .start    (sar_start),
      .cmp_high (cmp_high),
      .trial    (trial),
      .busy     (),
      .done     (sar_done)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV, ST_FINISH} acv_state_t;

   acv_state_t          st_r, st_nxt;
   logic [15:0]         cnt_r, cnt_nxt;
   logic [RES_BITS-1:0] latch_r, latch_nxt;
   logic                flag_n_r, flag_n_nxt;
   logic                drive_r, drive_nxt;
   logic                busy_r, busy_nxt;

   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      latch_nxt  = latch_r;
      flag_n_nxt = flag_n_r;
      drive_nxt  = drive_r;
      busy_nxt   = busy_r;
      target_nxt = target_r;
      sar_start  = 1'b0;
      case (st_r)
         ST_IDLE: begin
            if (wr_fall) begin
               flag_n_nxt = 1'b1;
               st_nxt     = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (wr_rise) begin
               target_nxt = acv_scale(vin_pos, vin_neg, vref_span);
               sar_start  = 1'b1;
               cnt_nxt    = 16'h0001;
               busy_nxt   = 1'b1;
               st_nxt     = ST_CONV;
            end
         end
         ST_CONV: begin
            // Fixed length, so each conversion takes the same time
            cnt_nxt = cnt_r + 16'h0001;
            if (sar_done) latch_nxt = trial;
            if (wr_fall) begin
               // New request aborts and restarts
               busy_nxt = 1'b0;
               st_nxt   = ST_ARMED;
            end else if (cnt_r >= 16'(CONV_CYC - 1)) begin
               st_nxt = ST_FINISH;
            end
         end
         ST_FINISH: begin
            busy_nxt   = 1'b0;
            flag_n_nxt = 1'b0;
            st_nxt     = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
      // Read in idle ends the unread state; conversion end wins over it below
      if (rd_active) begin
         drive_nxt = 1'b1;
         if (st_r == ST_IDLE) flag_n_nxt = 1'b1;
      end
      if (rd_rise || s2_r.cs_n) drive_nxt = 1'b0;
      if (st_r == ST_FINISH) flag_n_nxt = 1'b0;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r     <= ST_IDLE;
         cnt_r    <= 16'h0000;
         latch_r  <= RESULT_RST;
         flag_n_r <= 1'b1;
         drive_r  <= 1'b0;
         busy_r   <= 1'b0;
         target_r <= CODE_ZERO;
      end else begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         latch_r  <= latch_nxt;
         flag_n_r <= flag_n_nxt;
         drive_r  <= drive_nxt;
         busy_r   <= busy_nxt;
         target_r <= target_nxt;
      end
   end

   // Bus output flops
   acv_bus_t bus_r, bus_nxt;
   always_comb begin
      bus_nxt.dout = drive_nxt ? latch_nxt : 8'h00;
      bus_nxt.oe   = drive_nxt ? 8'hff : 8'h00;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) bus_r <= '0;
      else bus_r <= bus_nxt;
   end

   assign conversion_done_n = flag_n_r;
   assign result_bus        = bus_r;
   assign busy              = busy_r;
endmodule

// ### sim/acv_chk.sv
// Port checker for the converter control block
`timescale 1ns/100ps
module acv_chk
   import acv_pkg::*;
#(
   parameter int unsigned CONV_CYC = CONV_TESTED_CYC
) (
   input wire logic                 clock,
   input wire logic                 rst,
   input wire acv_pkg::acv_strobe_t host_in,
   input wire logic [RES_BITS-1:0]  vin_pos,
   input wire logic [RES_BITS-1:0]  vin_neg,
   input wire logic [RES_BITS-1:0]  vref_span,
   input wire logic                 conversion_done_n,
   input wire acv_pkg::acv_bus_t    result_bus,
   input wire logic                 busy
);
   // ----
   // Strobe sequences
   // ----
   localparam int DONE_CYC = CONV_CYC + 1;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence wr_held;
      (!host_in.cs_n && !host_in.wr_n) [*5];
   endsequence
   sequence rd_held;
      (!host_in.cs_n && !host_in.rd_n) [*5];
   endsequence
   // Conversion end moves the flag, so quiet only counts while idle
   sequence cs_idle;
      host_in.cs_n [*6] ##0 (!busy && !$fell(busy));
   endsequence
   // ----
   // Assertions
   // ----
   a_wr_flag_high: assert property (wr_held |-> conversion_done_n)
      else $error("flag low while write strobe held");
   a_wr_starts_conv: assert property (($rose(host_in.wr_n) && !host_in.cs_n) |-> ##[2:5] busy)
      else $error("no conversion after write rise");
   a_conv_time_bound: assert property ($rose(busy) |-> ##[1:DONE_CYC] $fell(conversion_done_n))
      else $error("conversion overran its limit");
   a_flag_at_end: assert property ($fell(conversion_done_n) |-> $past(busy))
      else $error("flag fell without a conversion");
   a_flag_holds: assert property ($fell(conversion_done_n) |=> !conversion_done_n [*3])
      else $error("flag rose before any read");
   a_read_drives: assert property (rd_held ##0 !busy |-> result_bus.oe == 8'hff && conversion_done_n)
      else $error("read did not drive bus or clear flag");
   a_rd_release: assert property ($rose(host_in.rd_n) |-> ##[1:5] result_bus.oe == 8'h00)
      else $error("bus not released after read");
   a_cs_ignore: assert property (cs_idle |-> result_bus.oe == 8'h00 && $stable(conversion_done_n))
      else $error("strobes acted while deselected");
endmodule

// ### sim/acv_host.sv
// Host bus model driving chip select and the strobes
`timescale 1ns/100ps
module acv_host
   import acv_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                conversion_done_n,
   output acv_pkg::acv_strobe_t     host_in
);
   initial host_in = 3'b111;
   // Pulse one strobe; hold sets a prompt or slow host
   task automatic strobe(input logic sel, input logic wr, input int hold);
      @(posedge clock);
      host_in <= {sel, ~wr, wr};
      repeat (hold) @(posedge clock);
      host_in <= {sel, 2'b11};
      repeat (6) @(posedge clock);
      host_in <= 3'b111;
   endtask
   // Bounded wait; the bench timeout covers a flag that never falls
   task automatic wait_done(input int extra);
      int n;
      n = 0;
      while (conversion_done_n !== 1'b0 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      repeat (RD_HOLDOFF_CYC + extra) @(posedge clock);
   endtask
endmodule

// ### sim/acv_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module acv_ctrl_tb;
   import acv_pkg::*;
   localparam int unsigned CYC = 10;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   acv_strobe_t host_in;
   logic [7:0]  p, n, s;
   logic [7:0]  vin_pos = 8'h00;
   logic [7:0]  vin_neg = 8'h00;
   logic [7:0]  vref_span = 8'h00;
   logic        conversion_done_n, busy, oe_q = 1'b0;
   acv_bus_t    result_bus;
   logic [7:0]  exp_q[$];
   int          n_mismatch = 0, n_tests = 0, seed = 19, cyc = 0, k;

   acv_ctrl #(.CONV_CYC(CYC)) i_acv_ctrl (.clock(clock), .rst(rst), .host_in(host_in),
      .vin_pos(vin_pos), .vin_neg(vin_neg), .vref_span(vref_span),
      .conversion_done_n(conversion_done_n), .result_bus(result_bus), .busy(busy));
   acv_host i_acv_host (.clock(clock), .conversion_done_n(conversion_done_n),
      .host_in(host_in));

   initial forever #20 clock = ~clock;

   // ----
   // Expectations and comparisons
   // ----
   function automatic logic [7:0] code_of(logic [7:0] a, logic [7:0] b, logic [7:0] r);
      int q;
      // Zero span saturates any positive difference
      q = (a <= b) ? 0 : ((r == 8'h00) ? 256 : ((a - b) * 256) / r);
      return (q > 255) ? 8'hff : q[7:0];
   endfunction
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Result monitor: one note off the queue per bus turn-on
   always @(posedge clock) begin
      oe_q <= (result_bus.oe === 8'hff);
      if (result_bus.oe === 8'hff && !oe_q) begin
         if (exp_q.size() == 0)
            check("unexpected drive", 8'h00, 8'hff);
         else
            check("result", exp_q.pop_front(), result_bus.dout);
      end
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // ----
   // Scenarios
   // ----
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      for (k = 0; k < 12; k++) begin
         p = 8'($random(seed));
         n = 8'($random(seed));
         s = 8'($random(seed));
         if (k == 0) n = p;
         if (k == 1) s = 8'h00;
         if (k == 2) {p, n, s} = 24'hff00ff;
         if (k == 3) {p, n} = 16'h10ff;
         @(posedge clock);
         vin_pos <= p;
         vin_neg <= n;
         vref_span <= s;
         i_acv_host.strobe(1'b0, 1'b1, 4 + k % 6);
         check("busy converting", 8'h01, {7'h0, busy});
         i_acv_host.wait_done(k % 3);
         check("busy idle", 8'h00, {7'h0, busy});
         check("flag unread", 8'h00, {7'h0, conversion_done_n});
         exp_q.push_back(code_of(p, n, s));
         i_acv_host.strobe(1'b0, 1'b0, 4 + k % 5);
         check("flag read", 8'h01, {7'h0, conversion_done_n});
         check("bus release", 8'h00, result_bus.oe);
      end
      $display("test conversions finished");
      i_acv_host.strobe(1'b0, 1'b1, 5);
      i_acv_host.wait_done(0);
      i_acv_host.strobe(1'b1, 1'b1, 5);
      check("flag deselected write", 8'h00, {7'h0, conversion_done_n});
      i_acv_host.strobe(1'b1, 1'b0, 5);
      check("flag deselected read", 8'h00, {7'h0, conversion_done_n});
      // New request over an unread result must raise the flag
      i_acv_host.strobe(1'b0, 1'b1, 5);
      check("flag rewrite", 8'h01, {7'h0, conversion_done_n});
      i_acv_host.wait_done(0);
      check("flag rewrite done", 8'h00, {7'h0, conversion_done_n});
      exp_q.push_back(code_of(vin_pos, vin_neg, vref_span));
      i_acv_host.strobe(1'b0, 1'b0, 5);
      check("flag final read", 8'h01, {7'h0, conversion_done_n});
      $display("test deselected strobes finished");
      end_of_test();
   end
endmodule

bind acv_ctrl acv_chk #(.CONV_CYC(CONV_CYC)) i_acv_chk (.clock(clock), .rst(rst),
   .host_in(host_in), .vin_pos(vin_pos), .vin_neg(vin_neg), .vref_span(vref_span),
   .conversion_done_n(conversion_done_n), .result_bus(result_bus), .busy(busy));
